// File: dct_chan.sv
module dct_chan import dct_pkg::*; (
	input logic clk_i,
	input logic srst_i,
	input dct_chan_cfg_t cfg_i,
	input logic restart_i,
	input logic tick_i,
	output logic [7:0] count_o,
	output logic active_o,
	output logic eoc_o
);
	logic [5:0] pre_q;
	logic [5:0] pre_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic act_q;
	logic act_d;
	logic eoc_q;
	// Source pulse reaches the prescaler only while running
	wire adv_w = tick_i & cfg_i.run & act_q;
	// Prescaler output pulse; a zero ratio wraps through 64 ticks
	wire step_w = adv_w & (pre_q == DCT_PRE_STEP);
	// Zero load wraps through 256 steps
	wire end_w = step_w & (cnt_q == DCT_CNT_END);

	// Next state of prescaler and counter
	always_comb begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		act_d = act_q;
		if (restart_i) begin
			pre_d = cfg_i.pre;
			cnt_d = cfg_i.load;
			act_d = 1'b1;
		end else if (end_w) begin
			pre_d = cfg_i.pre;
			if (cfg_i.cont) begin
				cnt_d = cfg_i.load;
			end else begin
				cnt_d = DCT_CNT_IDLE;
				act_d = 1'b0;
			end
		end else if (step_w) begin
			pre_d = cfg_i.pre;
			cnt_d = cnt_q - 8'h01;
		end else if (adv_w) begin
			pre_d = pre_q - 6'h01;
		end
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pre_q <= 6'h00;
			cnt_q <= 8'h00;
			act_q <= 1'b0;
			eoc_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			act_q <= act_d;
			eoc_q <= end_w;
		end
	end

	assign count_o = cnt_q;
	assign active_o = act_q;
	assign eoc_o = eoc_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Single pass stops at zero
	single_halt_a: assert property (
		end_w && !cfg_i.cont && !restart_i |=> !act_q && cnt_q == DCT_CNT_IDLE && eoc_q)
		else $error("single pass did not halt at zero");
	// Stopped counter keeps its value
	stop_hold_a: assert property (
		!cfg_i.run && !restart_i |=> $stable(cnt_q))
		else $error("stopped counter changed");
endmodule

// File: dct_peer.sv
// Far side of the block: timer pin source and a serial peer
module dct_peer #(
	parameter int BIT_CLKS = 64
) (
	input logic clk_i,
	input logic serial_transmit_line_i,
	output logic serial_receive_line_o,
	output logic timer_input_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_q; // Last character decoded
	logic frame_ok_q; // Start low and both stops high
	int got_n = 0; // Characters decoded so far
	// Idle levels: line high, pin low
	initial begin
		serial_receive_line_o = 1'b1;
		timer_input_pin_o = 1'b0;
	end
	// Start, eight data LSB first, one stop
	task automatic send_char(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_receive_line_o <= f[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
	endtask
	// Pin pulses, high for hi cycles, then low for four
	task automatic pulse_pin(input int n, input int hi);
		repeat (n) begin
			timer_input_pin_o <= 1'b1;
			repeat (hi) @(posedge clk_i);
			timer_input_pin_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask
	// Mid-bit sampling; a wrong bit rate garbles the data
	initial begin
		forever begin
			@(negedge serial_transmit_line_i);
			repeat (BIT_CLKS / 2) @(posedge clk_i);
			frame_ok_q = ~serial_transmit_line_i;
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge clk_i);
				got_q[i] = serial_transmit_line_i;
			end
			repeat (2) begin
				repeat (BIT_CLKS) @(posedge clk_i);
				frame_ok_q &= serial_transmit_line_i;
			end
			got_n++;
		end
	end
endmodule

// File: dct_pkg.sv
package dct_pkg;
	// Register byte offsets on the APB window
	localparam logic [5:0] DCT_A_CTRL = 6'h00;
	localparam logic [5:0] DCT_A_PRE0 = 6'h04;
	localparam logic [5:0] DCT_A_PRE1 = 6'h08;
	localparam logic [5:0] DCT_A_MODE = 6'h0c;
	localparam logic [5:0] DCT_A_LOAD0 = 6'h10;
	localparam logic [5:0] DCT_A_LOAD1 = 6'h14;
	localparam logic [5:0] DCT_A_CNT0 = 6'h18;
	localparam logic [5:0] DCT_A_CNT1 = 6'h1c;
	localparam logic [5:0] DCT_A_TXD = 6'h20;
	localparam logic [5:0] DCT_A_RXD = 6'h24;
	localparam logic [5:0] DCT_A_STAT = 6'h28;
	// Control register bit positions
	localparam int DCT_B_RUN0 = 0;
	localparam int DCT_B_CONT0 = 1;
	localparam int DCT_B_RUN1 = 2;
	localparam int DCT_B_CONT1 = 3;
	localparam int DCT_B_SER = 4;
	localparam int DCT_B_PAR = 5;
	localparam int DCT_B_RST0 = 6;
	localparam int DCT_B_RST1 = 7;
	localparam int DCT_CTRL_W = 6;
	// Mode register fields
	localparam int DCT_F_SRC = 0;
	localparam int DCT_SRC_W = 3;
	localparam int DCT_F_TSEL = 4;
	localparam int DCT_TSEL_W = 2;
	// Second counter input source codes
	localparam logic [2:0] DCT_SRC_INT = 3'h0;
	localparam logic [2:0] DCT_SRC_EXT = 3'h1;
	localparam logic [2:0] DCT_SRC_GATE = 3'h2;
	localparam logic [2:0] DCT_SRC_TRIG_RE = 3'h3;
	localparam logic [2:0] DCT_SRC_TRIG_NR = 3'h4;
	localparam logic [2:0] DCT_SRC_CASC = 3'h5;
	// Timer output source codes
	localparam logic [1:0] DCT_TO_OFF = 2'h0;
	localparam logic [1:0] DCT_TO_T0 = 2'h1;
	localparam logic [1:0] DCT_TO_T1 = 2'h2;
	localparam logic [1:0] DCT_TO_INT = 2'h3;
	// Internal clock divided by four
	localparam logic [1:0] DCT_DIV_LAST = 2'h3;
	// Sixteen samples per serial bit
	localparam logic [3:0] DCT_OVS_LAST = 4'hf;
	localparam logic [3:0] DCT_OVS_MID = 4'h7;
	// Start, eight data and two stop bits
	localparam logic [3:0] DCT_TX_BITS = 4'hb;
	localparam logic [3:0] DCT_TX_LAST = 4'h1;
	localparam logic [3:0] DCT_RX_LAST = 4'h7;
	// Prescaler and counter end values
	localparam logic [5:0] DCT_PRE_STEP = 6'h01;
	localparam logic [7:0] DCT_CNT_END = 8'h01;
	localparam logic [7:0] DCT_CNT_IDLE = 8'h00;
	// Settings that steer one counter channel
	typedef struct packed {
		logic run;
		logic cont;
		logic [5:0] pre;
		logic [7:0] load;
	} dct_chan_cfg_t;
	// Transmitter and receiver states
	typedef enum logic [1:0] {
		DCT_TX_IDLE = 2'b01,
		DCT_TX_SHIFT = 2'b10
	} dct_tx_st_t;
	typedef enum logic [3:0] {
		DCT_RX_IDLE = 4'b0001,
		DCT_RX_START = 4'b0010,
		DCT_RX_DATA = 4'b0100,
		DCT_RX_STOP = 4'b1000
	} dct_rx_st_t;
	// Odd parity bit over seven data bits
	function automatic logic dct_odd_par(input logic [6:0] d);
		return ~^d;
	endfunction
endpackage

// File: dct_top.sv
// Operation
// - Two 8-bit counters, each with prescaler
// - First prescaler internal; second internal or external
// - Prescaler divides by 1 through 64
// - Counter decrements loaded value 1 to 256
// - End of count raises its request line
// - Start, stop, resume or restart each counter
// - Single-pass halt or continuous reload
// - Counts readable anytime; prescalers not readable
// - Second source: clock over four or pin
// - Pin acts as clock, trigger or gate
// - Cascade first counter into second
// - Timer output pin from selectable source
// - Eight data bits; eighth is odd parity
// - Each sent character raises shared request
// - Parity error replaces received bit seven
// - Each received character raises receive request
// - Receive and transmit on their port lines
// - One start and two stop bits added
// - Bit rate comes from first counter
//
// The address map and the APB register port are this design's own decisions.
module dct_top import dct_pkg::*; (
	input logic clk_i,
	input logic srst_i,
	input logic psel_i,
	input logic penable_i,
	input logic pwrite_i,
	input logic [5:0] paddr_i,
	input logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input logic timer_input_pin_i,
	output logic timer_output_pin_o,
	input logic serial_receive_line_i,
	output logic serial_transmit_line_o,
	output logic receive_request_o,
	output logic transmit_or_first_count_request_o,
	output logic second_count_request_o
);
	// Bus answer registers
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rdata_w;
	// Software settings
	logic [5:0] ctrl_q;
	logic [5:0] pre0_q;
	logic [5:0] pre1_q;
	logic [2:0] src_q;
	logic [1:0] tsel_q;
	logic [7:0] load0_q;
	logic [7:0] load1_q;
	logic rst0_q;
	logic rst1_q;
	// Clock divider and pin samples
	logic [1:0] div_q;
	logic tin_q;
	logic tin_prev_q;
	logic timer_output_pin_q;
	// Serial state
	dct_tx_st_t tx_st_q;
	logic [10:0] tx_sh_q;
	logic [3:0] tx_div_q;
	logic [3:0] tx_cnt_q;
	logic tx_done_q;
	logic tx_line_q;
	dct_rx_st_t rx_st_q;
	logic rx_q;
	logic [7:0] rx_sh_q;
	logic [3:0] rx_div_q;
	logic [3:0] rx_cnt_q;
	logic [7:0] rxd_q;
	logic rx_full_q;
	logic rx_done_q;
	// Request pulses
	logic req3_q;
	logic req4_q;
	logic req5_q;
	// Channel results
	logic [7:0] cnt0_w;
	logic [7:0] cnt1_w;
	logic act0_w;
	logic act1_w;
	logic t0_eoc_w;
	logic t1_eoc_w;
	dct_chan_cfg_t cfg0_w;
	dct_chan_cfg_t cfg1_w;

	// APB phases: one wait state, then the answer
	wire acc_w = psel_i & penable_i & ~pready_q;
	wire done_w = psel_i & penable_i & pready_q;
	wire wr_w = done_w & pwrite_i;
	wire rd_w = done_w & ~pwrite_i;
	// Address decode
	wire sel_ctrl_w = (paddr_i == DCT_A_CTRL);
	wire sel_pre0_w = (paddr_i == DCT_A_PRE0);
	wire sel_pre1_w = (paddr_i == DCT_A_PRE1);
	wire sel_mode_w = (paddr_i == DCT_A_MODE);
	wire sel_load0_w = (paddr_i == DCT_A_LOAD0);
	wire sel_load1_w = (paddr_i == DCT_A_LOAD1);
	wire sel_cnt0_w = (paddr_i == DCT_A_CNT0);
	wire sel_cnt1_w = (paddr_i == DCT_A_CNT1);
	wire sel_txd_w = (paddr_i == DCT_A_TXD);
	wire sel_rxd_w = (paddr_i == DCT_A_RXD);
	wire sel_stat_w = (paddr_i == DCT_A_STAT);
	// Prescalers are write only, counts read only
	wire wr_hit_w = sel_ctrl_w | sel_pre0_w | sel_pre1_w | sel_mode_w | sel_load0_w
		| sel_load1_w | sel_txd_w;
	wire rd_hit_w = sel_ctrl_w | sel_mode_w | sel_load0_w | sel_load1_w | sel_cnt0_w
		| sel_cnt1_w | sel_rxd_w | sel_stat_w;
	wire err_w = pwrite_i ? ~wr_hit_w : ~rd_hit_w;
	// Control bit names
	wire ser_en_w = ctrl_q[DCT_B_SER];
	wire par_en_w = ctrl_q[DCT_B_PAR];
	wire tx_busy_w = (tx_st_q != DCT_TX_IDLE);

	// Read data selection
	always_comb begin
		rdata_w = 32'h0000_0000;
		if (sel_ctrl_w) begin
			rdata_w = {26'h0, ctrl_q};
		end else if (sel_mode_w) begin
			rdata_w = {26'h0, tsel_q, 1'b0, src_q};
		end else if (sel_load0_w) begin
			rdata_w = {24'h0, load0_q};
		end else if (sel_load1_w) begin
			rdata_w = {24'h0, load1_q};
		end else if (sel_cnt0_w) begin
			rdata_w = {24'h0, cnt0_w};
		end else if (sel_cnt1_w) begin
			rdata_w = {24'h0, cnt1_w};
		end else if (sel_rxd_w) begin
			rdata_w = {24'h0, rxd_q};
		end else if (sel_stat_w) begin
			rdata_w = {28'h0, act1_w, act0_w, rx_full_q, tx_busy_w};
		end
	end

	// Bus answer: data and error sampled in the first access cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc_w;
			pslverr_q <= acc_w & err_w;
			if (acc_w) begin
				prdata_q <= pwrite_i ? 32'h0000_0000 : rdata_w;
			end
		end
	end

	// Software writes to the setting registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_q <= 6'h00;
			pre0_q <= 6'h00;
			pre1_q <= 6'h00;
			src_q <= DCT_SRC_INT;
			tsel_q <= DCT_TO_OFF;
			load0_q <= 8'h00;
			load1_q <= 8'h00;
		end else if (wr_w) begin
			if (sel_ctrl_w) ctrl_q <= pwdata_i[DCT_CTRL_W-1:0];
			if (sel_pre0_w) pre0_q <= pwdata_i[5:0];
			if (sel_pre1_w) pre1_q <= pwdata_i[5:0];
			if (sel_mode_w) src_q <= pwdata_i[DCT_F_SRC +: DCT_SRC_W];
			if (sel_mode_w) tsel_q <= pwdata_i[DCT_F_TSEL +: DCT_TSEL_W];
			if (sel_load0_w) load0_q <= pwdata_i[7:0];
			if (sel_load1_w) load1_q <= pwdata_i[7:0];
		end
	end

	// Restart bits act once and read back as zero
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rst0_q <= 1'b0;
			rst1_q <= 1'b0;
		end else begin
			rst0_q <= wr_w & sel_ctrl_w & pwdata_i[DCT_B_RST0];
			rst1_q <= wr_w & sel_ctrl_w & pwdata_i[DCT_B_RST1];
		end
	end

	// Internal clock over four, and pin samples for edge finding
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			div_q <= 2'h0;
			tin_q <= 1'b0;
			tin_prev_q <= 1'b0;
			rx_q <= 1'b1;
		end else begin
			div_q <= div_q + 2'h1;
			tin_q <= timer_input_pin_i;
			tin_prev_q <= tin_q;
			rx_q <= serial_receive_line_i;
		end
	end
	wire int_tick_w = (div_q == DCT_DIV_LAST);
	wire tin_rise_w = tin_q & ~tin_prev_q;

	// Pin role follows the mode field
	wire trig_re_w = (src_q == DCT_SRC_TRIG_RE) & tin_rise_w;
	// A running non-retriggerable count ignores further edges
	wire trig_nr_w = (src_q == DCT_SRC_TRIG_NR) & tin_rise_w & ~act1_w;
	// Second source mux; cascade from first end
	wire t1_tick_w = (src_q == DCT_SRC_EXT) ? tin_rise_w
		: (src_q == DCT_SRC_GATE) ? (int_tick_w & tin_q)
		: (src_q == DCT_SRC_CASC) ? t0_eoc_w
		: int_tick_w;
	wire t1_rst_w = rst1_q | trig_re_w | trig_nr_w;

	assign cfg0_w = {ctrl_q[DCT_B_RUN0], ctrl_q[DCT_B_CONT0], pre0_q, load0_q};
	assign cfg1_w = {ctrl_q[DCT_B_RUN1], ctrl_q[DCT_B_CONT1], pre1_q, load1_q};
	// First channel on the internal clock only
	dct_chan u_first_counter (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.cfg_i(cfg0_w),
		.restart_i(rst0_q),
		.tick_i(int_tick_w),
		.count_o(cnt0_w),
		.active_o(act0_w),
		.eoc_o(t0_eoc_w)
	);
	dct_chan u_second_counter (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.cfg_i(cfg1_w),
		.restart_i(t1_rst_w),
		.tick_i(t1_tick_w),
		.count_o(cnt1_w),
		.active_o(act1_w),
		.eoc_o(t1_eoc_w)
	);

	// Timer output toggles on the chosen source
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			timer_output_pin_q <= 1'b0;
		end else begin
			case (tsel_q)
				DCT_TO_T0: timer_output_pin_q <= timer_output_pin_q ^ t0_eoc_w;
				DCT_TO_T1: timer_output_pin_q <= timer_output_pin_q ^ t1_eoc_w;
				DCT_TO_INT: timer_output_pin_q <= timer_output_pin_q ^ int_tick_w;
				default: timer_output_pin_q <= 1'b0;
			endcase
		end
	end

	// Sixteen serial ticks per bit, from the first end of count
	wire ser_tick_w = ser_en_w & t0_eoc_w;
	// Bit seven is data or odd parity
	wire tx_b7_w = par_en_w ? dct_odd_par(pwdata_i[6:0]) : pwdata_i[7];
	// Start bit low, two stop bits high
	wire [10:0] tx_frame_w = {2'b11, tx_b7_w, pwdata_i[6:0], 1'b0};
	// Writes while busy or with serial off are dropped
	wire tx_go_w = wr_w & sel_txd_w & ser_en_w & ~tx_busy_w;

	// Transmitter: shifts out LSB first
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_st_q <= DCT_TX_IDLE;
			tx_sh_q <= 11'h7ff;
			tx_div_q <= 4'h0;
			tx_cnt_q <= 4'h0;
			tx_done_q <= 1'b0;
		end else begin
			tx_done_q <= 1'b0;
			case (tx_st_q)
				DCT_TX_IDLE: if (tx_go_w) begin
					tx_sh_q <= tx_frame_w;
					tx_cnt_q <= DCT_TX_BITS;
					tx_div_q <= 4'h0;
					tx_st_q <= DCT_TX_SHIFT;
				end
				DCT_TX_SHIFT: if (ser_tick_w) begin
					tx_div_q <= tx_div_q + 4'h1;
					if (tx_div_q == DCT_OVS_LAST) begin
						tx_sh_q <= {1'b1, tx_sh_q[10:1]};
						tx_cnt_q <= tx_cnt_q - 4'h1;
						if (tx_cnt_q == DCT_TX_LAST) begin
							tx_st_q <= DCT_TX_IDLE;
							tx_done_q <= 1'b1;
						end
					end
				end
				default: tx_st_q <= DCT_TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_line_q <= 1'b1;
		end else begin
			tx_line_q <= (tx_st_q == DCT_TX_SHIFT) ? tx_sh_q[0] : 1'b1;
		end
	end

	// Odd parity over all eight received bits must be one
	wire perr_w = ~^rx_sh_q;
	// Parity error flag takes bit seven's place
	wire [7:0] rx_word_w = par_en_w ? {perr_w, rx_sh_q[6:0]} : rx_sh_q;
	wire rx_fin_w = ser_tick_w & (rx_st_q == DCT_RX_STOP) & (rx_div_q == DCT_OVS_LAST);

	// Receiver relies on start, eight data, one stop
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_st_q <= DCT_RX_IDLE;
			rx_div_q <= 4'h0;
			rx_cnt_q <= 4'h0;
			rx_sh_q <= 8'h00;
		end else if (ser_tick_w) begin
			rx_div_q <= rx_div_q + 4'h1;
			case (rx_st_q)
				DCT_RX_IDLE: begin
					rx_div_q <= 4'h0;
					if (!rx_q) rx_st_q <= DCT_RX_START;
				end
				// Mid-bit check filters short glitches
				DCT_RX_START: if (rx_div_q == DCT_OVS_MID) begin
					rx_div_q <= 4'h0;
					rx_cnt_q <= 4'h0;
					rx_st_q <= rx_q ? DCT_RX_IDLE : DCT_RX_DATA;
				end
				DCT_RX_DATA: if (rx_div_q == DCT_OVS_LAST) begin
					rx_sh_q <= {rx_q, rx_sh_q[7:1]};
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_cnt_q == DCT_RX_LAST) rx_st_q <= DCT_RX_STOP;
				end
				// Stop bit level is not judged; extra stops look idle
				DCT_RX_STOP: if (rx_div_q == DCT_OVS_LAST) rx_st_q <= DCT_RX_IDLE;
				default: rx_st_q <= DCT_RX_IDLE;
			endcase
		end
	end

	// Received word, full flag: a new word wins over a read clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rxd_q <= 8'h00;
			rx_full_q <= 1'b0;
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= rx_fin_w;
			if (rx_fin_w) rxd_q <= rx_word_w;
			rx_full_q <= rx_fin_w | (rx_full_q & ~(rd_w & sel_rxd_w));
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			req3_q <= 1'b0;
			req4_q <= 1'b0;
			req5_q <= 1'b0;
		end else begin
			req3_q <= rx_done_q;
			req4_q <= t0_eoc_w | tx_done_q;
			req5_q <= t1_eoc_w;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign timer_output_pin_o = timer_output_pin_q;
	assign serial_transmit_line_o = tx_line_q;
	assign receive_request_o = req3_q;
	assign transmit_or_first_count_request_o = req4_q;
	assign second_count_request_o = req5_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Bus answers after exactly one wait state
	apb_wait_a: assert property (
		psel_i && penable_i && !pready_o |=> pready_o)
		else $error("bus answer not after one wait");
	second_req_a: assert property (
		t1_eoc_w |=> second_count_request_o)
		else $error("second count request missing");
	tx_req_a: assert property (
		tx_done_q |=> transmit_or_first_count_request_o)
		else $error("transmit request missing");
	rx_req_a: assert property (
		rx_fin_w |=> ##1 receive_request_o)
		else $error("receive request missing");
	tx_start_a: assert property (
		tx_go_w |-> ##2 !serial_transmit_line_o)
		else $error("start bit not driven low");
	tx_frame_a: assert property (
		tx_go_w |=> tx_sh_q[8] == $past(tx_b7_w) && tx_sh_q[10:9] == 2'b11)
		else $error("frame bit seven or stops wrong");
	rx_par_a: assert property (
		rx_fin_w |=> rxd_q == $past(rx_word_w) && rx_full_q)
		else $error("received word not stored");
	timer_output_pin_t0_a: assert property (
		tsel_q == DCT_TO_T0 && t0_eoc_w |=> timer_output_pin_o != $past(timer_output_pin_q))
		else $error("timer output did not toggle");
	cv_tx_c: cover property (tx_done_q);
	cv_rx_c: cover property (rx_fin_w && par_en_w);
	cv_casc_c: cover property (src_q == DCT_SRC_CASC && t1_eoc_w);
	cv_trig_c: cover property (trig_nr_w ##[1:200] t1_eoc_w);
endmodule

// File: dual_counter_timer_serial_bench.sv
module dual_counter_timer_serial_bench import dct_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [5:0] pad = 6'h00;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd, rd;
	logic prdy, perr, err, timer_input_pin, timer_output_pin, timer_output_pin_d, rxl, txl, rq_rx, rq_t0, rq_t1;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0, n_rx = 0, n_t0 = 0, n_t1 = 0;
	int l_t0 = 0, g_t0 = 0, l_t1 = 0, g_t1 = 0, l_tg = 0, g_tg = 0, t, k;
	int pre[4] = '{1, 2, 0, 1}; // Zero means 64
	int lod[4] = '{3, 3, 1, 0}; // Zero means 256
	logic [5:0] bad[4] = '{DCT_A_PRE0, DCT_A_PRE1, DCT_A_TXD, 6'h2c};
	logic [7:0] tx[2] = '{8'ha5, 8'h37};
	logic [7:0] rx[2] = '{8'hc6, 8'h03};
	dct_top DUT (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(prdy), .pslverr_o(perr), .timer_input_pin_i(timer_input_pin),
		.timer_output_pin_o(timer_output_pin), .serial_receive_line_i(rxl),
		.serial_transmit_line_o(txl), .receive_request_o(rq_rx),
		.transmit_or_first_count_request_o(rq_t0), .second_count_request_o(rq_t1));
	dct_peer peer (.clk_i(clk_i), .serial_transmit_line_i(txl),
		.serial_receive_line_o(rxl), .timer_input_pin_o(timer_input_pin));
	// 50 MHz clock
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// Pulse counts and gaps, taken on pre-edge values
	always @(posedge clk_i) begin
		cyc++;
		if (rq_rx === 1'b1) n_rx++;
		if (rq_t0 === 1'b1) begin
			n_t0++;
			g_t0 = cyc - l_t0;
			l_t0 = cyc;
		end
		if (rq_t1 === 1'b1) begin
			n_t1++;
			g_t1 = cyc - l_t1;
			l_t1 = cyc;
		end
		if (timer_output_pin !== timer_output_pin_d) begin
			g_tg = cyc - l_tg;
			l_tg = cyc;
		end
		timer_output_pin_d = timer_output_pin;
	end
	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; held until pready is seen at an edge
	task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		pad <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		rd = prd;
		err = perr;
		if (prdy !== 1'b1) check("pready", 0, 1);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_i);
	endtask
	// Bounded wait for a counter to reach a value
	task automatic wait_n(ref int c, input int v, input int lim);
		repeat (lim) if (c < v) @(posedge clk_i);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog, well beyond the expected run
	initial begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		check("idle tx line", txl, 1);
		check("idle requests", {rq_rx, rq_t0, rq_t1}, 0);
		apb(0, DCT_A_CTRL, 0);
		check("ctrl reset", rd, 0);
		check("ctrl no error", err, 0);
		// Continuous periods over ratio and load boundaries
		for (int i = 0; i < 4; i++) begin
			apb(1, DCT_A_PRE0, pre[i]);
			apb(1, DCT_A_LOAD0, lod[i]);
			apb(1, DCT_A_CTRL, 32'h43);
			t = n_t0;
			wait_n(n_t0, t + 3, 4000);
			t = 4 * (pre[i] ? pre[i] : 64) * (lod[i] ? lod[i] : 256);
			check("first period", g_t0, t);
		end
		// Single pass stops at zero
		apb(1, DCT_A_LOAD0, 32'h2);
		apb(1, DCT_A_CTRL, 32'h41);
		repeat (40) @(posedge clk_i);
		t = n_t0;
		repeat (60) @(posedge clk_i);
		check("single pass", n_t0, t);
		apb(0, DCT_A_CNT0, 0);
		check("halted count", rd, 0);
		// Prescalers unreadable, counts and unmapped places refused
		foreach (bad[i]) begin
			apb(0, bad[i], 0);
			check("read refused", err, 1);
		end
		apb(1, DCT_A_CNT0, 32'h5);
		check("write refused", err, 1);
		// Stop freezes, resume continues from the frozen value
		apb(1, DCT_A_PRE0, 32'h4);
		apb(1, DCT_A_LOAD0, 32'hc8);
		apb(1, DCT_A_CTRL, 32'h41);
		repeat (100) @(posedge clk_i);
		apb(1, DCT_A_CTRL, 32'h0);
		apb(0, DCT_A_CNT0, 0);
		t = rd;
		repeat (50) @(posedge clk_i);
		apb(0, DCT_A_CNT0, 0);
		check("stopped count", rd, t);
		apb(1, DCT_A_CTRL, 32'h1);
		repeat (64) @(posedge clk_i);
		apb(0, DCT_A_CNT0, 0);
		check("resumed count", (rd < t) && (rd + 7 > t), 1);
		// Second counter: internal over four, then cascaded
		apb(1, DCT_A_PRE0, 32'h1);
		apb(1, DCT_A_PRE1, 32'h1);
		apb(1, DCT_A_LOAD0, 32'h2);
		apb(1, DCT_A_LOAD1, 32'h3);
		for (int m = 0; m < 2; m++) begin
			apb(1, DCT_A_MODE, m ? DCT_SRC_CASC : DCT_SRC_INT);
			apb(1, DCT_A_CTRL, 32'hcf);
			t = n_t1;
			wait_n(n_t1, t + 3, 400);
			check("second period", g_t1, m ? 24 : 12);
		end
		// Timer output from each source, then off
		for (int s = 1; s < 4; s++) begin
			apb(1, DCT_A_MODE, (s << DCT_F_TSEL) | DCT_SRC_CASC);
			repeat (80) @(posedge clk_i);
			check("timer_output_pin gap", g_tg, s == 1 ? 8 : s == 2 ? 24 : 4);
		end
		apb(1, DCT_A_MODE, 32'h0);
		repeat (4) @(posedge clk_i);
		check("timer_output_pin off", timer_output_pin, 0);
		// Pin as clock, then as gate
		apb(1, DCT_A_LOAD1, 32'h5);
		apb(1, DCT_A_MODE, DCT_SRC_EXT);
		apb(1, DCT_A_CTRL, 32'h84);
		peer.pulse_pin(3, 4);
		apb(0, DCT_A_CNT1, 0);
		check("pin clocked", rd, 2);
		apb(1, DCT_A_MODE, DCT_SRC_GATE);
		apb(1, DCT_A_CTRL, 32'h84);
		repeat (40) @(posedge clk_i);
		apb(0, DCT_A_CNT1, 0);
		check("gate closed", rd, 5);
		peer.pulse_pin(1, 12);
		apb(0, DCT_A_CNT1, 0);
		check("gate open", (rd > 1) && (rd < 4), 1);
		// Second pin edge mid-count: retriggers or is ignored
		apb(1, DCT_A_LOAD1, 32'h14);
		for (int m = 3; m < 5; m++) begin
			apb(1, DCT_A_MODE, m);
			apb(1, DCT_A_CTRL, 32'h4);
			repeat (40) @(posedge clk_i);
			k = n_t1;
			t = cyc;
			peer.pulse_pin(2, 36);
			wait_n(n_t1, k + 1, 200);
			t = l_t1 - t - (m == 3 ? 120 : 80);
			check("trigger end", (t >= 0) && (t <= 10), 1);
		end
		// Transmit with and without parity; a write while busy is dropped
		apb(1, DCT_A_LOAD0, 32'h1);
		for (int p = 0; p < 2; p++) begin
			apb(1, DCT_A_CTRL, p ? 32'h73 : 32'h53);
			t = peer.got_n;
			apb(1, DCT_A_TXD, tx[p]);
			apb(1, DCT_A_TXD, 32'h0);
			wait_n(peer.got_n, t + 1, 1500);
			check("sent char", peer.got_q, p ? {~^tx[p][6:0], tx[p][6:0]} : tx[p]);
			check("frame bits", peer.frame_ok_q, 1);
			// Peer decodes mid stop bit; let the last stop bit finish
			repeat (40) @(posedge clk_i);
		end
		repeat (800) @(posedge clk_i);
		check("busy write dropped", peer.got_n, t + 1);
		// Receive; a bad parity shows in bit seven
		for (int p = 0; p < 2; p++) begin
			apb(1, DCT_A_CTRL, p ? 32'h73 : 32'h53);
			t = n_rx;
			peer.send_char(rx[p]);
			wait_n(n_rx, t + 1, 200);
			check("rx request", n_rx, t + 1);
			apb(0, DCT_A_RXD, 0);
			check("rx char", rd, p ? {~^rx[p], rx[p][6:0]} : rx[p]);
		end
		wrap_up();
	end
endmodule
